// File: rtl/nph_host.v
// host controller driving the nand pin bus for page read and column change
`timescale 1ns/1ps
`default_nettype none
`include "nph_map.vh"
module nph_host #(
  parameter BUS_W = 8,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // user request
  input wire req_valid,
  output wire req_ready,
  input wire [1:0] req_op,
  input wire [29:0] req_addr,
  input wire [11:0] req_len,
  input wire wp_enable,
  // user read data
  output wire rd_valid,
  input wire rd_ready,
  output wire [BUS_W-1:0] rd_data,
  output wire busy,
  // nand pins
  output reg ce_n_q,
  output reg cle_q,
  output reg ale_q,
  output reg we_n_q,
  output reg read_strobe_n_q,
  output reg wp_n_q,
  output reg whole_chip_protect_q,
  output reg [BUS_W-1:0] io_out_q,
  output reg io_oe_q,
  input wire [BUS_W-1:0] io_in,
  input wire rb_n
);
  localparam S_IDLE = 8'h01;
  localparam S_CMD1 = 8'h02;
  localparam S_ADDR = 8'h04;
  localparam S_CMD2 = 8'h08;
  localparam S_WAITB = 8'h10;
  localparam S_WAITR = 8'h20;
  localparam S_READ = 8'h40;
  localparam S_DONE = 8'h80;

  reg [7:0] st_q;
  reg [29:0] addr_q;
  reg [1:0] op_q;
  reg [11:0] left_q;
  reg [2:0] acyc_q;
  reg [3:0] tmr_q;
  reg phase_q;
  reg [1:0] rb_sync_q;
  reg [BUS_W-1:0] io_s1_q;
  reg [BUS_W-1:0] io_s2_q;
  reg word_valid_q;
  reg [BUS_W-1:0] word_q;
  // fifo room and synchronised ready level
  wire fifo_in_ready;
  wire rb_ready;
  // read-word hand-off to the fifo
  wire capture;
  wire strobe_room;
  // combinational bus word for command and address cycles
  reg [7:0] abyte;
  reg [2:0] acnt;
  reg [BUS_W-1:0] bus_word;

  // ready/busy passes two flops before use
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rb_sync_q <= 2'h0;
      io_s1_q <= {BUS_W{1'b0}};
      io_s2_q <= {BUS_W{1'b0}};
    end else begin
      rb_sync_q <= {rb_sync_q[0], rb_n};
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end
  assign rb_ready = rb_sync_q[1];

  assign req_ready = (st_q == S_IDLE);
  assign busy = (st_q != S_IDLE);

  // address byte per cycle, layout differs by bus width
  always @* begin
    abyte = 8'h00;
    acnt = (op_q == `NPH_OP_COLCHG) ? `NPH_COL_CYCLES : `NPH_ADDR_CYCLES;
    if (BUS_W == 8) begin
      // byte mode: column bits 0..11, row from 12
      case (acyc_q)
        3'h0: abyte = addr_q[7:0];
        3'h1: abyte = {4'h0, addr_q[11:8]};
        3'h2: abyte = addr_q[19:12];
        3'h3: abyte = addr_q[27:20];
        3'h4: abyte = {6'h00, addr_q[29:28]};
        default: abyte = 8'h00;
      endcase
    end else begin
      // word mode: column bits 0..10, row from 11
      case (acyc_q)
        3'h0: abyte = addr_q[7:0];
        3'h1: abyte = {5'h00, addr_q[10:8]};
        3'h2: abyte = addr_q[18:11];
        3'h3: abyte = addr_q[26:19];
        3'h4: abyte = {6'h00, addr_q[28:27]};
        default: abyte = 8'h00;
      endcase
    end
  end

  // command or address byte widened to the bus width
  always @* begin
    bus_word = {BUS_W{1'b0}};
    if (st_q == S_CMD1) begin
      bus_word[7:0] = (op_q == `NPH_OP_COLCHG) ? `NPH_CMD_COL_CHANGE : `NPH_CMD_READ_SETUP;
    end else if (st_q == S_CMD2) begin
      bus_word[7:0] = (op_q == `NPH_OP_COLCHG) ? `NPH_CMD_COL_CONFIRM : `NPH_CMD_READ_CONFIRM;
    end else begin
      // upper byte stays low on a wide bus
      bus_word[7:0] = abyte;
    end
  end

  // protect pins kept apart from the sequencer so no state can skip them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_n_q <= 1'b0;
      whole_chip_protect_q <= 1'b0;
    end else begin
      // host only releases protect when user asks
      // user level is registered once, so a glitch never reaches the pin
      wp_n_q <= wp_enable;
      whole_chip_protect_q <= 1'b0;
    end
  end

  // word of a fall is taken once it has crossed both flops
  assign capture = (st_q == S_READ) && phase_q && (tmr_q >= `NPH_RE_HIGH_CYC);
  // a word still on its way to the fifo already claims a slot
  assign strobe_room = fifo_in_ready && !word_valid_q;

  // one fifo word for every read strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_valid_q <= 1'b0;
      word_q <= {BUS_W{1'b0}};
    end else begin
      word_valid_q <= capture;
      if (capture) begin
        word_q <= io_s2_q;
      end
    end
  end

  // a request is taken only in idle, so one bus sequence runs at a time
  // main sequencer; each pin cycle is a low phase then a high phase
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      addr_q <= 30'h0;
      op_q <= 2'h0;
      left_q <= 12'h000;
      acyc_q <= 3'h0;
      tmr_q <= 4'h0;
      phase_q <= 1'b0;
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      read_strobe_n_q <= 1'b1;
      // bus released until the first command
      io_out_q <= {BUS_W{1'b0}};
      io_oe_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          ce_n_q <= 1'b1;
          io_oe_q <= 1'b0;
          if (req_valid) begin
            addr_q <= req_addr;
            op_q <= req_op;
            left_q <= (req_len > `NPH_PAGE_BYTES) ? `NPH_PAGE_BYTES : req_len;
            ce_n_q <= 1'b0;
            phase_q <= 1'b0;
            tmr_q <= 4'h0;
            acyc_q <= 3'h0;
            st_q <= S_CMD1;
          end
        end
        S_CMD1, S_ADDR, S_CMD2: begin
          io_oe_q <= 1'b1;
          cle_q <= (st_q != S_ADDR);
          ale_q <= (st_q == S_ADDR);
          // bus word is set up with the strobe fall and held to its rise
          io_out_q <= bus_word;
          tmr_q <= tmr_q + 4'h1;
          if (!phase_q) begin
            we_n_q <= 1'b0;
            if (tmr_q >= `NPH_WE_LOW_CYC) begin
              phase_q <= 1'b1;
              tmr_q <= 4'h0;
            end
          end else begin
            // rising strobe edge latches the bus
            we_n_q <= 1'b1;
            if (tmr_q >= `NPH_WE_HIGH_CYC) begin
              phase_q <= 1'b0;
              tmr_q <= 4'h0;
              if (st_q == S_CMD1) begin
                st_q <= S_ADDR;
              end else if (st_q == S_ADDR) begin
                if (acyc_q == acnt - 3'h1) begin
                  st_q <= S_CMD2;
                end
                acyc_q <= acyc_q + 3'h1;
              end else begin
                st_q <= (op_q == `NPH_OP_COLCHG) ? S_WAITR : S_WAITB;
              end
            end
          end
        end
        S_WAITB: begin
          cle_q <= 1'b0;
          ale_q <= 1'b0;
          io_oe_q <= 1'b0;
          // deselect during load; load carries on
          ce_n_q <= 1'b1;
          tmr_q <= tmr_q + 4'h1;
          if (!rb_ready || tmr_q >= `NPH_BUSY_WAIT_CYC) begin
            tmr_q <= 4'h0;
            st_q <= S_WAITR;
          end
        end
        S_WAITR: begin
          cle_q <= 1'b0;
          ale_q <= 1'b0;
          io_oe_q <= 1'b0;
          if (rb_ready) begin
            ce_n_q <= 1'b0;
            phase_q <= 1'b0;
            tmr_q <= 4'h0;
            st_q <= (left_q == 12'h000) ? S_DONE : S_READ;
          end
        end
        S_READ: begin
          tmr_q <= tmr_q + 4'h1;
          if (!phase_q) begin
            // stall read strobe while fifo has no free slot
            if (strobe_room) begin
              read_strobe_n_q <= 1'b0;
              if (tmr_q >= `NPH_RE_LOW_CYC) begin
                phase_q <= 1'b1;
                tmr_q <= 4'h0;
              end
            end else begin
              tmr_q <= 4'h0;
            end
          end else begin
            read_strobe_n_q <= 1'b1;
            if (tmr_q >= `NPH_RE_HIGH_CYC) begin
              phase_q <= 1'b0;
              tmr_q <= 4'h0;
              // one word per strobe; capture runs in its own process
              left_q <= left_q - 12'h001;
              // last strobe of the request closes the sequence
              if (left_q == 12'h001) begin
                st_q <= S_DONE;
              end
            end
          end
        end
        S_DONE: begin
          // last word is already on its way to the fifo
          read_strobe_n_q <= 1'b1;
          // release chip select so an idle device can drop to standby
          ce_n_q <= 1'b1;
          st_q <= S_IDLE;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // data-in cycles unused: read-only host keeps latches low
  // protect strap held low so program would be allowed
  nph_fifo #(
    .WIDTH(BUS_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(word_valid_q),
    .in_ready(fifo_in_ready),
    .in_data(word_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule
`default_nettype wire

// File: rtl/nph_map.vh
// constants for the nand page-read host controller
`ifndef NPH_MAP_VH
`define NPH_MAP_VH
`define NPH_CMD_READ_SETUP 8'h00
`define NPH_CMD_READ_CONFIRM 8'h30
`define NPH_CMD_COL_CHANGE 8'h05
`define NPH_CMD_COL_CONFIRM 8'he0
`define NPH_ADDR_CYCLES 3'h5
`define NPH_COL_CYCLES 3'h2
`define NPH_PAGE_BYTES 12'h870
`define NPH_WE_LOW_CYC 4'h1
`define NPH_WE_HIGH_CYC 4'h1
`define NPH_RE_LOW_CYC 4'h1
`define NPH_RE_HIGH_CYC 4'h1
`define NPH_BUSY_WAIT_CYC 4'h4
`define NPH_OP_READ 2'h0
`define NPH_OP_COLCHG 2'h1
`endif

// File: rtl/nph_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module nph_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  // honest full and empty from the word count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage has no reset, pointers do
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  // pointer and count update
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/nph_host_monitor.sv
// pin-protocol checker for the nand page-read host
`timescale 1ns/1ps
`default_nettype none
module nph_host_monitor #(
  parameter BUS_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // user side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic wp_enable,
  input wire logic busy,
  // nand pins
  input wire logic ce_n_q,
  input wire logic cle_q,
  input wire logic ale_q,
  input wire logic we_n_q,
  input wire logic read_strobe_n_q,
  input wire logic wp_n_q,
  input wire logic whole_chip_protect_q,
  input wire logic [BUS_W-1:0] io_out_q,
  input wire logic io_oe_q,
  input wire logic rb_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // write strobe: two cycles low, then high
  sequence s_we_pulse;
    !we_n_q [*2] ##1 we_n_q;
  endsequence
  a_write_pulse: assert property ($fell(we_n_q) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_write_hold: assert property ($fell(we_n_q) |=> $stable(io_out_q) && $stable(cle_q))
    else $error("bus moved under write strobe");
  a_latch_excl: assert property (!(cle_q && ale_q))
    else $error("both latch enables high");
  a_strobe_select: assert property ((!we_n_q || !read_strobe_n_q) |-> !ce_n_q)
    else $error("strobe while deselected");
  a_write_drive: assert property (!we_n_q |-> io_oe_q)
    else $error("bus not driven on write");
  a_read_float: assert property (!read_strobe_n_q |-> !io_oe_q)
    else $error("bus driven on read");
  a_busy_wait: assert property (!rb_n |-> read_strobe_n_q [*3])
    else $error("read strobe while device busy");
  a_wp_follow: assert property ($changed(wp_enable) |=> wp_n_q == $past(wp_enable))
    else $error("write protect not following");
  a_protect_off: assert property (!whole_chip_protect_q)
    else $error("chip protect driven high");
  a_take_busy: assert property (req_valid && req_ready |=> busy && !req_ready)
    else $error("request not taken");
  a_idle_standby: assert property ($rose(req_ready) |-> ##[0:2] ce_n_q)
    else $error("chip select held in idle");
endmodule
bind nph_host nph_host_monitor #(.BUS_W(BUS_W)) u_mon (.clk, .nrst, .req_valid, .req_ready,
  .wp_enable, .busy, .ce_n_q, .cle_q, .ale_q, .we_n_q, .read_strobe_n_q, .wp_n_q,
  .whole_chip_protect_q, .io_out_q, .io_oe_q, .rb_n);
`default_nettype wire

// File: verification/nph_dev_model.sv
// behavioural nand device answering page reads and column changes
`timescale 1ns/1ps
`default_nettype none
module nph_dev_model (
  // pins from the host
  input wire logic ce_n_q,
  input wire logic cle_q,
  input wire logic ale_q,
  input wire logic we_n_q,
  input wire logic read_strobe_n_q,
  // no program or erase ever accepted
  input wire logic wp_n_q,
  input wire logic whole_chip_protect_q,
  input wire logic [7:0] io_out_q,
  // long busy select
  input wire logic slow,
  // answer to the host
  output logic [7:0] dq,
  output logic rb_n
);
  logic [7:0] ab [0:7];
  logic [15:0] col;
  int na;
  initial begin
    dq = 8'h5a;
    rb_n = 1'b1;
    col = 16'h0;
    na = 0;
  end
  always @(posedge we_n_q) begin
    if (!ce_n_q && cle_q) begin
      na = 0;
      // busy runs on whatever chip select does
      if (io_out_q == 8'h30) begin
        rb_n = 1'b0;
        rb_n <= #(slow ? 3000 : 300) 1'b1;
      end
      if (io_out_q == 8'h30 || io_out_q == 8'he0) col = {ab[1], ab[0]};
    end else if (!ce_n_q && ale_q) begin
      ab[na[2:0]] = io_out_q;
      na = na + 1;
    end else if (!ce_n_q) col = col + 16'h1;
  end
  // next word after access delay, counter steps
  always @(negedge read_strobe_n_q) begin
    if (!ce_n_q && rb_n) begin
      dq <= #8 col[7:0] ^ {col[11:8], col[15:12]} ^ ab[2] ^ ab[3] ^ ab[4];
      col = col + 16'h1;
    end
  end
  // deselect inverts the word on dq; the device keeps driving the bus
  always @(posedge ce_n_q) dq = ~dq;
endmodule
`default_nettype wire

// File: verification/nph_host_tb.sv
// randomised page-read bench for the nand host controller
`timescale 1ns/1ps
`default_nettype none
module nph_host_tb;
  logic clk, nrst, req_valid, rd_ready, wp_enable, slow, stall;
  logic [1:0] req_op;
  logic [29:0] req_addr, page, a;
  logic [11:0] req_len, n;
  wire req_ready, rd_valid, busy, ce_n_q, cle_q, ale_q, we_n_q, read_strobe_n_q;
  wire wp_n_q, whole_chip_protect_q, io_oe_q, rb_n;
  wire [7:0] rd_data, io_out_q, io_in, dq;
  int errors, check_count, seed, i;
  logic [7:0] exp_q[$];
  // bus level seen by the host; the device reads io_out_q direct
  assign io_in = io_oe_q ? io_out_q : dq;
  nph_host #(.BUS_W(8), .FIFO_DEPTH(32), .FIFO_AW(5)) u_dut (.clk, .nrst, .req_valid,
    .req_ready, .req_op, .req_addr, .req_len, .wp_enable, .rd_valid, .rd_ready, .rd_data,
    .busy, .ce_n_q, .cle_q, .ale_q, .we_n_q, .read_strobe_n_q, .wp_n_q,
    .whole_chip_protect_q, .io_out_q, .io_oe_q, .io_in, .rb_n);
  nph_dev_model u_dev (.ce_n_q, .cle_q, .ale_q, .we_n_q, .read_strobe_n_q, .wp_n_q,
    .whole_chip_protect_q, .io_out_q, .slow, .dq, .rb_n);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input logic [7:0] seen, input logic [7:0] want);
    check_count = check_count + 1;
    if (seen !== want) begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task final_report;
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // page content as the device stores it
  function logic [7:0] pdat(input logic [29:0] ad, input logic [11:0] c);
    return c[7:0] ^ {c[11:8], 4'h0} ^ ad[19:12] ^ ad[27:20] ^ {6'h0, ad[29:28]};
  endfunction
  // request held until taken; expected words queued up front
  task req(input logic [1:0] op, input logic [29:0] ad, input logic [11:0] len);
    int k;
    @(posedge clk);
    req_op <= op;
    req_addr <= ad;
    req_len <= len;
    req_valid <= 1'b1;
    if (op == 2'h0) page = ad;
    for (k = 0; k < len; k++) exp_q.push_back(pdat(page, ad[11:0] + k[11:0]));
    k = 0;
    do @(negedge clk); while (req_ready !== 1'b1 && ++k < 5000);
    if (k >= 5000) errors = errors + 1;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task wait_done;
    int k;
    for (k = 0; k < 30000 && (exp_q.size() != 0 || busy !== 1'b0); k++) @(negedge clk);
    if (k >= 30000) errors = errors + 1;
  endtask
  // drain side stalls at random, fully while stall is set
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      // a word with nothing queued for it is a mismatch of its own
      if (exp_q.size() == 0)
        check(8'(exp_q.size()), 8'h01);
      else
        check(rd_data, exp_q.pop_front());
    end
    rd_ready <= !stall && ($random(seed) & 3) != 0;
  end
  // watchdog sized well past the whole run
  initial begin
    #(40 * 90000);
    errors = errors + 1;
    final_report;
  end
  initial begin
    seed = 32'h422b;
    errors = 0;
    check_count = 0;
    stall = 1'b0;
    nrst = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_addr = 30'h0;
    req_len = 12'h0;
    wp_enable = 1'b0;
    slow = 1'b0;
    rd_ready = 1'b1;
    repeat (8) @(posedge clk);
    check(ce_n_q, 8'h1);
    check(wp_n_q, 8'h0);
    nrst <= 1'b1;
    // corners: empty read at top row, last words of page, slow load
    req(2'h0, 30'h3ffff000, 12'h0);
    wait_done;
    slow <= 1'b1;
    req(2'h0, 30'h2a5c5860, 12'h10);
    wait_done;
    // drain stalled: fifo fills, host must hold off
    stall = 1'b1;
    req(2'h1, 30'h00000005, 12'h28);
    repeat (400) @(posedge clk);
    check(busy, 8'h1);
    stall = 1'b0;
    wait_done;
    // back to back without waiting
    req(2'h0, 30'h15a3c000, 12'h3);
    req(2'h1, 30'h000007ff, 12'h4);
    wait_done;
    for (i = 0; i < 14; i++) begin
      a = $random(seed);
      n = $random(seed) & 12'h2f;
      a[11:0] = a[11:0] % 12'h820;
      @(posedge clk);
      slow <= $random(seed);
      wp_enable <= $random(seed);
      @(posedge clk);
      @(negedge clk);
      check(wp_n_q, {7'h0, wp_enable});
      req(i < 2 ? 2'h0 : 2'($random(seed) & 1), a, n);
      wait_done;
    end
    check(busy, 8'h0);
    final_report;
  end
endmodule
`default_nettype wire
